// [inc/mps_regs.svh]
/*
 * Register map, field positions, reset values and frame limits of the
 * PHY-select and frame-statistics block.
 * Assumes byte addressing with one aligned 32-bit word per register.
 */
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define MPS_NET_CONTROL_OFS   8'h00
`define MPS_NET_CONFIG_OFS    8'h04
`define MPS_PHY_IF_CTRL_OFS   8'h08
`define MPS_INT_STATUS_OFS    8'h0c
`define MPS_INT_MASK_OFS      8'h10
`define MPS_COUNT_BASE_OFS    8'h20

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define MPS_RX_ENABLE_BIT     2
`define MPS_STATS_WREN_BIT    7
`define MPS_BIG_FRAMES_BIT    8
`define MPS_RMII_SEL_BIT      0
`define MPS_XCVR_TRANSCEIVER_CLOCK_ENABLE_BIT    1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MPS_NET_CONTROL_RST   32'h0000_0000
`define MPS_NET_CONFIG_RST    32'h0000_0000
`define MPS_PHY_IF_CTRL_RST   32'h0000_0000
`define MPS_INT_MASK_RST      32'h0000_0000

// ----------------------------------------------------------------------
// frame length limits in bytes
// ----------------------------------------------------------------------
`define MPS_MIN_FRAME_LEN     11'h040
`define MPS_MAX_FRAME_LEN     11'h5ee
`define MPS_BIG_FRAME_LEN     11'h600

`endif

// [inc/mps_pkg.sv]
/*
 * Types shared by the statistics block and its surroundings.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mps_pkg;

    // one report per received frame, valid for the cycle of done
    typedef struct packed {
        logic        done;
        logic [10:0] length;
        logic        fcsError;
        logic        alignError;
        logic        symbolError;
        logic        pause;
        logic        addrMatch;
        logic        copied;
    } mps_rx_event_type;

    // one report per finished transmit attempt sequence
    typedef struct packed {
        logic       done;
        logic       underrun;
        logic       retryExceeded;
        logic [4:0] collisions;
    } mps_tx_event_type;

    typedef enum logic [1:0] {
        MPS_RESP_OKAY   = 2'h0,
        MPS_RESP_SLVERR = 2'h2
    } mps_resp_type;

endpackage : mps_pkg

// [design/mps_stats.sv]
/*
 * PHY interface select register and saturating frame-statistics
 * counters of an Ethernet MAC, behind an AXI4-Lite slave.
 * Assumes frame reports arrive from MAC logic on the same clock as
 * one-cycle pulses, and that the clock gate cell sits outside.
 */
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
// Functional notes
// - interface-select bit one picks RMII, zero MII
// - clock-enable bit gates transceiver input clock
// - counter read returns value, then clears
// - counters stick at all ones
// - receive counters count only with receive enable
// - counter writes need control bit 7 set
// - 16-bit good pause frames received counter
// - config bit 8 raises limit to 1536
// - 24-bit frames sent OK counter
// - 16-bit exactly-one-collision sent frames counter
// - 16-bit two-to-fifteen collision sent counter
// - 24-bit good received, matched, copied counter
// - 8-bit bad CRC or symbol error counter
module mps_stats #(
    parameter int NUM_COUNT = 6
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire mps_pkg::mps_rx_event_type rxEvent,
    input  wire mps_pkg::mps_tx_event_type txEvent,
    output logic                           rmiiMode,
    output logic                           xcvrClkEnable,
    output logic                           irq
);

`include "mps_regs.svh"

    // ------------------------------------------------------------------
    // counter widths: pause, sent, one-coll, several-coll, rx ok, bad crc
    // ------------------------------------------------------------------
    localparam int CNT_W [NUM_COUNT] = '{16, 24, 16, 16, 24, 8};

    logic [31:0] netControl_ff;
    logic [31:0] netConfig_ff;
    logic [31:0] phyIfCtrl_ff;
    logic [31:0] intMask_ff;
    logic [NUM_COUNT-1:0] intStatus_ff;
    logic [23:0] count_ff [NUM_COUNT];
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [1:0]  rresp_ff;
    logic [31:0] rdata_ff;

    // ------------------------------------------------------------------
    // write channel decode
    // ------------------------------------------------------------------
    wire        wrFire   = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
    wire [31:0] byteMask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [7:0]  wrAddr   = s_axi_awaddr;
    wire        wrCtl    = wrFire && wrAddr == `MPS_NET_CONTROL_OFS;
    wire        wrCfg    = wrFire && wrAddr == `MPS_NET_CONFIG_OFS;
    wire        wrPhy    = wrFire && wrAddr == `MPS_PHY_IF_CTRL_OFS;
    wire        wrSts    = wrFire && wrAddr == `MPS_INT_STATUS_OFS;
    wire        wrMsk    = wrFire && wrAddr == `MPS_INT_MASK_OFS;
    wire [7:0]  wrCntIdx = (wrAddr - `MPS_COUNT_BASE_OFS) >> 2;
    wire        wrCntHit = wrAddr >= `MPS_COUNT_BASE_OFS
                           && wrCntIdx < 8'(NUM_COUNT)
                           && wrAddr[1:0] == 2'h0;
    wire        wrMapped = wrCtl || wrCfg || wrPhy || wrSts || wrMsk
                           || (wrFire && wrCntHit);
    wire        statsWrEn = netControl_ff[`MPS_STATS_WREN_BIT];

    assign s_axi_awready = wrFire;
    assign s_axi_wready  = wrFire;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    // ------------------------------------------------------------------
    // read channel decode
    // ------------------------------------------------------------------
    wire        rdFire   = s_axi_arvalid && !rvalid_ff;
    wire [7:0]  rdAddr   = s_axi_araddr;
    wire [7:0]  rdCntIdx = (rdAddr - `MPS_COUNT_BASE_OFS) >> 2;
    wire        rdCntHit = rdAddr >= `MPS_COUNT_BASE_OFS
                           && rdCntIdx < 8'(NUM_COUNT)
                           && rdAddr[1:0] == 2'h0;
    wire        rdCtl    = rdAddr == `MPS_NET_CONTROL_OFS;
    wire        rdCfg    = rdAddr == `MPS_NET_CONFIG_OFS;
    wire        rdPhy    = rdAddr == `MPS_PHY_IF_CTRL_OFS;
    wire        rdSts    = rdAddr == `MPS_INT_STATUS_OFS;
    wire        rdMsk    = rdAddr == `MPS_INT_MASK_OFS;
    wire        rdMapped = rdCtl || rdCfg || rdPhy || rdSts || rdMsk
                           || rdCntHit;
    wire [23:0] rdCount  = rdCntHit ? count_ff[rdCntIdx[2:0]] : 24'h0;
    wire [31:0] nxt_rdata =
        rdCtl    ? netControl_ff :
        rdCfg    ? netConfig_ff :
        rdPhy    ? phyIfCtrl_ff :
        rdSts    ? {{(32-NUM_COUNT){1'b0}}, intStatus_ff} :
        rdMsk    ? intMask_ff :
        rdCntHit ? {8'h0, rdCount} : 32'h0;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // ------------------------------------------------------------------
    // frame qualification
    // ------------------------------------------------------------------
    wire [10:0] maxLen  = netConfig_ff[`MPS_BIG_FRAMES_BIT]
                          ? `MPS_BIG_FRAME_LEN : `MPS_MAX_FRAME_LEN;
    wire rxEnable  = netControl_ff[`MPS_RX_ENABLE_BIT];
    wire rxValidLen = rxEvent.length >= `MPS_MIN_FRAME_LEN
                      && rxEvent.length <= maxLen;
    wire rxClean   = !rxEvent.fcsError && !rxEvent.alignError
                     && !rxEvent.symbolError;
    wire rxCount   = rxEvent.done && rxEnable;
    wire rxGood    = rxCount && rxValidLen && rxClean;
    wire txOk      = txEvent.done && !txEvent.underrun
                     && !txEvent.retryExceeded;

    wire [NUM_COUNT-1:0] countInc;
    assign countInc[0] = rxGood && rxEvent.pause;
    assign countInc[1] = txOk;
    assign countInc[2] = txOk && txEvent.collisions == 5'h01;
    assign countInc[3] = txOk && txEvent.collisions >= 5'h02
                         && txEvent.collisions <= 5'h0f;
    assign countInc[4] = rxGood && rxEvent.addrMatch
                         && rxEvent.copied;
    assign countInc[5] = rxCount && rxValidLen && !rxEvent.alignError
                         && (rxEvent.fcsError
                             || rxEvent.symbolError);

    // ------------------------------------------------------------------
    // statistics counters
    // ------------------------------------------------------------------
    logic [NUM_COUNT-1:0] countFull;

    for (genvar i = 0; i < NUM_COUNT; i++) begin : g_count
        localparam logic [23:0] ONES = 24'((25'h1 << CNT_W[i]) - 25'h1);
        wire        hitWr  = wrFire && wrCntHit && wrCntIdx[2:0] == 3'(i);
        wire        doLoad = hitWr && statsWrEn;
        wire        doClr  = rdFire && rdCntHit
                             && rdCntIdx[2:0] == 3'(i);
        wire [23:0] merged = (count_ff[i] & ~byteMask[23:0])
                             | (s_axi_wdata[23:0] & byteMask[23:0]);
        wire        full   = count_ff[i] == ONES;
        // a load wins over both clear and increment: software intent
        wire [23:0] nxt_count =
            doLoad      ? merged & ONES :
            doClr       ? {23'h0, countInc[i]} :
            countInc[i] && !full ? count_ff[i] + 24'h1 :
            count_ff[i];

        assign countFull[i] = countInc[i] && (count_ff[i] + 24'h1) == ONES
                              && !doClr && !doLoad;

        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                count_ff[i] <= 24'h0;
            end else begin
                count_ff[i] <= nxt_count;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt: a counter counting up to all ones sets its sticky bit
    // ------------------------------------------------------------------
    // a new saturation in the same cycle as a write-one-to-clear is kept
    wire [NUM_COUNT-1:0] nxt_intStatus =
        (intStatus_ff & ~(wrSts ? s_axi_wdata[NUM_COUNT-1:0]
                                  & byteMask[NUM_COUNT-1:0]
                                : {NUM_COUNT{1'b0}}))
        | countFull;

    assign irq = |(intStatus_ff & intMask_ff[NUM_COUNT-1:0]);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    wire [31:0] nxt_netControl = (netControl_ff & ~byteMask)
                                 | (s_axi_wdata & byteMask);
    wire [31:0] nxt_netConfig  = (netConfig_ff & ~byteMask)
                                 | (s_axi_wdata & byteMask);
    wire [31:0] phyFieldMask   = 32'h0000_0003;
    wire [31:0] nxt_phyIfCtrl  = ((phyIfCtrl_ff & ~byteMask)
                                  | (s_axi_wdata & byteMask)) & phyFieldMask;
    wire [31:0] nxt_intMask    = ((intMask_ff & ~byteMask)
                                  | (s_axi_wdata & byteMask))
                                 & {{(32-NUM_COUNT){1'b0}}, {NUM_COUNT{1'b1}}};

    assign rmiiMode      = phyIfCtrl_ff[`MPS_RMII_SEL_BIT];
    // level to the clock gate cell; zero stops the transceiver clock
    assign xcvrClkEnable = phyIfCtrl_ff[`MPS_XCVR_TRANSCEIVER_CLOCK_ENABLE_BIT];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            netControl_ff <= `MPS_NET_CONTROL_RST;
            netConfig_ff  <= `MPS_NET_CONFIG_RST;
            phyIfCtrl_ff  <= `MPS_PHY_IF_CTRL_RST;
            intMask_ff    <= `MPS_INT_MASK_RST;
            intStatus_ff  <= {NUM_COUNT{1'b0}};
        end else begin
            if (wrCtl) begin
                netControl_ff <= nxt_netControl;
            end
            if (wrCfg) begin
                netConfig_ff <= nxt_netConfig;
            end
            if (wrPhy) begin
                phyIfCtrl_ff <= nxt_phyIfCtrl;
            end
            if (wrMsk) begin
                intMask_ff <= nxt_intMask;
            end
            intStatus_ff <= nxt_intStatus;
        end
    end

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    // an ignored counter write still answers OKAY: only the data is lost
    wire [1:0] nxt_bresp = wrMapped ? mps_pkg::MPS_RESP_OKAY
                                    : mps_pkg::MPS_RESP_SLVERR;
    wire [1:0] nxt_rresp = rdMapped ? mps_pkg::MPS_RESP_OKAY
                                    : mps_pkg::MPS_RESP_SLVERR;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
        end else if (wrFire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= nxt_bresp;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= 2'h0;
            rdata_ff  <= 32'h0;
        end else if (rdFire) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

endmodule : mps_stats

// [testbench/mps_stats_monitor.sv]
/*
 * Checker for the register port and PHY select outputs of mps_stats.
 * Assumes one clock, async active-high reset and the designer's offsets.
 */
module mps_stats_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        rmiiMode,
    input wire logic        xcvrClkEnable,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  lastAr_ff;
    logic [7:0]  nxt_lastAr;
    logic        phyWr_ff;
    logic [1:0]  phyBits_ff;
    logic [31:0] upMask;
    logic        arMapped;

    assign nxt_lastAr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : lastAr_ff;
    assign arMapped   = lastAr_ff inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20,
                                          8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
    // bits above each counter's width must never leak out on a read
    assign upMask = (lastAr_ff == 8'h34) ? 32'hffffff00 :
                    (lastAr_ff == 8'h08) ? 32'hfffffffc :
                    (lastAr_ff inside {8'h24, 8'h30}) ? 32'hff000000 :
                    (lastAr_ff inside {8'h20, 8'h28, 8'h2c}) ? 32'hffff0000 : 32'h00000000;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastAr_ff  <= 8'h00;
            phyWr_ff   <= 1'b0;
            phyBits_ff <= 2'h0;
        end else begin
            lastAr_ff  <= nxt_lastAr;
            phyWr_ff   <= s_axi_awvalid && s_axi_awready && (s_axi_awaddr == 8'h08);
            phyBits_ff <= s_axi_wdata[1:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    write_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response missing");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
                                  |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    data_hold_a: assert property (s_axi_rvalid && !s_axi_rready
                                  |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    upper_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & upMask) == 32'h0)
        else $error("unimplemented bits read nonzero");
    unmapped_err_a: assert property (s_axi_rvalid && !arMapped
                                     |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    rmii_select_a: assert property ($changed(rmiiMode) |->
                                    phyWr_ff && rmiiMode == phyBits_ff[0])
        else $error("interface select changed without write");
    clock_gate_a: assert property ($changed(xcvrClkEnable) |->
                                   phyWr_ff && xcvrClkEnable == phyBits_ff[1])
        else $error("clock enable changed without write");

    cover property (s_axi_rvalid && s_axi_rdata != 32'h0 && lastAr_ff >= 8'h20);
    cover property ($rose(irq));
    cover property ($rose(rmiiMode));
endmodule : mps_stats_monitor

bind mps_stats mps_stats_monitor u_mps_stats_monitor (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rmiiMode(rmiiMode), .xcvrClkEnable(xcvrClkEnable), .irq(irq));

// [testbench/mps_frame_model.sv]
/*
 * Frame report source standing in for the MAC receive and transmit paths.
 * Assumes its tasks are entered just after a rising edge of clk.
 */
module mps_frame_model (
    input  wire logic                 clk,
    output mps_pkg::mps_rx_event_type rxEvent,
    output mps_pkg::mps_tx_event_type txEvent
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rxEvent = '0;
        txEvent = '0;
    end

    // fields are inverted after each pulse so stale values never look valid
    // f = {fcs, align, symbol, pause, match}; copied follows match
    task automatic rx(input logic [10:0] len, input logic [4:0] f);
        rxEvent <= {1'b1, len, f, f[0]};
        @(posedge clk);
        rxEvent <= ~rxEvent;
        @(posedge clk);
    endtask : rx

    // bad = {underrun, retry limit exceeded}
    task automatic tx(input logic [1:0] bad, input logic [4:0] col);
        txEvent <= {1'b1, bad, col};
        @(posedge clk);
        txEvent <= ~txEvent;
        @(posedge clk);
    endtask : tx
endmodule : mps_frame_model

// [testbench/mps_stats_bench.sv]
/*
 * Self-checking bench for mps_stats: register port, counters, interrupt.
 * Assumes the frame model drives the report inputs on the same clock.
 */
module mps_stats_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                      clk, sys_rst, rmiiMode, xcvrClkEnable, irq;
    logic [7:0]                s_axi_awaddr, s_axi_araddr;
    logic [31:0]               s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]                s_axi_wstrb, hs;
    logic [1:0]                s_axi_bresp, s_axi_rresp, lastResp;
    logic                      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                      s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                      s_axi_rvalid, s_axi_rready;
    mps_pkg::mps_rx_event_type rxEvent;
    mps_pkg::mps_tx_event_type txEvent;
    int                        miscompares, compares;

    assign hs = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};

    mps_stats u_mps_stats (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rxEvent(rxEvent), .txEvent(txEvent), .rmiiMode(rmiiMode),
        .xcvrClkEnable(xcvrClkEnable), .irq(irq));
    mps_frame_model u_mps_frame_model (.clk(clk), .rxEvent(rxEvent), .txEvent(txEvent));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic waitHigh(input int i);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hs[i] !== 1'b1 && n < 50);
        if (hs[i] !== 1'b1) begin
            miscompares++;
            $display("BAD %0t handshake timeout", $time);
            complete_run();
        end
    endtask : waitHigh

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        waitHigh(0);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        @(posedge clk);
        s_axi_bready  <= 1'b1;
        waitHigh(1);
        lastResp = s_axi_bresp;
        s_axi_bready  <= 1'b0;
    endtask : axiWrite

    // counters are read after every short burst so none can saturate unseen
    task automatic rdCheck(input logic [7:0] a, input logic [31:0] want);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        waitHigh(2);
        s_axi_arvalid <= 1'b0;
        @(posedge clk);
        s_axi_rready  <= 1'b1;
        waitHigh(3);
        rd = s_axi_rdata;
        lastResp = s_axi_rresp;
        s_axi_rready  <= 1'b0;
        check(rd, want);
    endtask : rdCheck

    task automatic phyScenario();
        rdCheck(8'h08, 32'h0);
        axiWrite(8'h08, 32'h00000003);
        check({30'h0, xcvrClkEnable, rmiiMode}, 32'h3);
        axiWrite(8'h08, 32'hfffffffe);
        check({30'h0, xcvrClkEnable, rmiiMode}, 32'h2);
        rdCheck(8'h08, 32'h2);
        axiWrite(8'h08, 32'h00000001);
        check({30'h0, xcvrClkEnable, rmiiMode}, 32'h1);
    endtask : phyScenario

    task automatic rxScenario();
        axiWrite(8'h00, 32'h4);
        u_mps_frame_model.rx(11'h040, 5'h03);
        u_mps_frame_model.rx(11'h5ee, 5'h03);
        u_mps_frame_model.rx(11'h5ef, 5'h03);
        u_mps_frame_model.rx(11'h03f, 5'h03);
        u_mps_frame_model.rx(11'h064, 5'h11);
        u_mps_frame_model.rx(11'h064, 5'h05);
        u_mps_frame_model.rx(11'h064, 5'h19);
        u_mps_frame_model.rx(11'h064, 5'h02);
        rdCheck(8'h20, 32'h3);
        rdCheck(8'h30, 32'h2);
        rdCheck(8'h34, 32'h2);
        rdCheck(8'h20, 32'h0);
        axiWrite(8'h04, 32'h100);
        u_mps_frame_model.rx(11'h600, 5'h01);
        rdCheck(8'h30, 32'h1);
        axiWrite(8'h00, 32'h0);
        u_mps_frame_model.rx(11'h040, 5'h03);
        rdCheck(8'h30, 32'h0);
        axiWrite(8'h04, 32'h0);
    endtask : rxScenario

    task automatic txScenario();
        u_mps_frame_model.tx(2'h0, 5'h00);
        u_mps_frame_model.tx(2'h0, 5'h01);
        u_mps_frame_model.tx(2'h0, 5'h02);
        u_mps_frame_model.tx(2'h0, 5'h0f);
        u_mps_frame_model.tx(2'h1, 5'h10);
        u_mps_frame_model.tx(2'h2, 5'h01);
        rdCheck(8'h24, 32'h4);
        rdCheck(8'h28, 32'h1);
        rdCheck(8'h2c, 32'h2);
        // an increment on the clearing edge must survive the clear
        u_mps_frame_model.tx(2'h0, 5'h00);
        fork
            u_mps_frame_model.tx(2'h0, 5'h00);
            rdCheck(8'h24, 32'h1);
        join
        rdCheck(8'h24, 32'h1);
    endtask : txScenario

    task automatic writeScenario();
        axiWrite(8'h28, 32'h5);
        rdCheck(8'h28, 32'h0);
        axiWrite(8'h00, 32'h84);
        axiWrite(8'h28, 32'h12345);
        rdCheck(8'h28, 32'h2345);
        s_axi_wstrb <= 4'h2;
        axiWrite(8'h28, 32'h0000ffff);
        s_axi_wstrb <= 4'hf;
        rdCheck(8'h28, 32'hff00);
        axiWrite(8'h34, 32'hfe);
        axiWrite(8'h10, 32'h20);
        u_mps_frame_model.rx(11'h064, 5'h11);
        check({31'h0, irq}, 32'h1);
        axiWrite(8'h10, 32'h0);
        check({31'h0, irq}, 32'h0);
        axiWrite(8'h10, 32'h20);
        u_mps_frame_model.rx(11'h064, 5'h11);
        rdCheck(8'h34, 32'hff);
        rdCheck(8'h0c, 32'h20);
        axiWrite(8'h0c, 32'h20);
        check({31'h0, irq}, 32'h0);
        axiWrite(8'h00, 32'h0);
    endtask : writeScenario

    task automatic errorScenario();
        rdCheck(8'h40, 32'h0);
        check({30'h0, lastResp}, 32'h2);
        axiWrite(8'h44, 32'h1);
        check({30'h0, lastResp}, 32'h2);
    endtask : errorScenario

    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        phyScenario();
        rxScenario();
        txScenario();
        writeScenario();
        errorScenario();
        complete_run();
    end
endmodule : mps_stats_bench
